/* File: logic/dfx_decrement_exec.sv */
// Execution of the three decrement-file instructions on a four-phase
// instruction cycle, with data memory, accumulator and flags, reached
// over AXI4-Lite. Assumes next_two_word comes from fetch logic on ref_clk.
//
// Notes on behaviour
// - Plain decrement subtracts one; destination bit picks accumulator or file.
// - Plain decrement decodes when upper six bits are 000001.
// - Plain decrement updates all five flags; null flag set when result 00h.
// - Bank bit 0 selects access bank; 1 uses bank pointer for RAM bank.
// - Bank bit 0, extended set on, address <= 95: indexed literal offset.
// - Plain decrement: one cycle, phases decode, read, compute, write.
// - Skip-on-zero (001011) stores result, skips if zero, flags untouched.
// - Skip-on-nonzero (010011) stores result, flags untouched, skips if nonzero.
// - Skipping a two-word instruction takes three cycles with no-operation fill.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "dfx_consts.svh"

module dfx_decrement_exec #(
  parameter int BANKS = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic next_two_word,
  output logic exec_busy,
  output logic exec_done
);
  import dfx_pkg::*;

  localparam int DEPTH = BANKS * 256;

  // The bank pointer is four bits, so more than 16 banks cannot be reached
  if (BANKS < 1 || BANKS > 16)
  begin : g_banks_check
    $error("BANKS must lie in 1..16");
  end

  // Merge a written word into the old one under the byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Memory bound test one bit wider, so a full 4096-byte memory does not
  // wrap its bound to zero and refuse every address
  function automatic logic in_mem(input logic [11:0] a);
    return {1'b0, a} < 13'(DEPTH);
  endfunction

  // Effective 12-bit data address for a file operand
  function automatic logic [11:0] file_addr(input dfx_instr_s ins, input logic ext_en,
                                            input logic [3:0] bank, input logic [11:0] ibase);
    logic [11:0] a;
    if (ins.acc)
      a = {bank, ins.faddr};
    else if (ext_en && ins.faddr <= `DFX_INDEX_LIMIT)
      a = 12'(ibase + {4'h0, ins.faddr});
    else if (ins.faddr < `DFX_ACCESS_SPLIT)
      a = {4'h0, ins.faddr};
    else
      a = {`DFX_SFR_BANK, ins.faddr};
    return a;
  endfunction

  logic [7:0] ram [0:DEPTH-1];
  dfx_state_e state_ff, nxt_state;
  dfx_instr_s instr_ff;
  dfx_op_e op_ff;
  dfx_flags_s flags_ff;
  dfx_flags_s dec_flags_q;
  logic [11:0] eaddr_ff, maddr_ff, ibase_ff;
  logic [7:0] operand_ff, result_ff, accum_ff;
  logic ext_en_ff, ill_ff, skip_ff, done_ff;
  logic [3:0] bank_ff;
  logic [1:0] phase_ff, nop_words_ff, cyc_ff;
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // Decode of the opcode held in the instruction register
  dfx_op_e dec_op;
  assign dec_op = (instr_ff.opc == `DFX_OPC_DEC) ? OP_DEC :
                  (instr_ff.opc == `DFX_OPC_DSZ) ? OP_DSZ :
                  (instr_ff.opc == `DFX_OPC_DSNZ) ? OP_DSNZ : OP_NONE;

  // AXI write side: address and data are taken in either order
  wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire busy = state_ff != ST_IDLE;
  wire wr_ctrl = do_write && awaddr_ff == `DFX_CTRL_OFS;
  wire wr_instr = do_write && awaddr_ff == `DFX_INSTR_OFS && !busy;
  wire wr_accum = do_write && awaddr_ff == `DFX_ACCUM_OFS && !busy;
  wire wr_status = do_write && awaddr_ff == `DFX_STATUS_OFS && !busy;
  wire wr_maddr = do_write && awaddr_ff == `DFX_MADDR_OFS;
  wire wr_mdata = do_write && awaddr_ff == `DFX_MDATA_OFS && !busy;
  wire wr_ibase = do_write && awaddr_ff == `DFX_IBASE_OFS;
  wire wr_mapped = awaddr_ff[7:2] <= 6'h06 && awaddr_ff[1:0] == 2'h0;
  wire [31:0] ctrl_word = {20'h0, bank_ff, 7'h0, ext_en_ff};
  wire [31:0] status_word = {14'h0, cyc_ff, 6'h0, ill_ff, busy, 3'h0, flags_ff};
  wire [31:0] ctrl_new = apply_strb(ctrl_word, wdata_ff, wstrb_ff);
  wire [31:0] instr_new = apply_strb(32'h0, wdata_ff, wstrb_ff);
  wire [31:0] accum_new = apply_strb({24'h0, accum_ff}, wdata_ff, wstrb_ff);
  wire [31:0] stat_new = apply_strb(status_word, wdata_ff, wstrb_ff);
  wire [31:0] maddr_new = apply_strb({20'h0, maddr_ff}, wdata_ff, wstrb_ff);
  wire [31:0] mdata_new = apply_strb({24'h0, ram[maddr_ff]}, wdata_ff, wstrb_ff);
  wire [31:0] ibase_new = apply_strb({20'h0, ibase_ff}, wdata_ff, wstrb_ff);
  wire ram_hit = in_mem(maddr_ff);

  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign exec_busy = busy;
  assign exec_done = done_ff;

  // Read data selection
  wire [7:0] ra = s_axi_araddr;
  wire rd_mapped = ra[7:2] <= 6'h06 && ra[1:0] == 2'h0;
  wire [31:0] rd_word = (ra == `DFX_CTRL_OFS) ? ctrl_word :
                        (ra == `DFX_INSTR_OFS) ? {16'h0, instr_ff} :
                        (ra == `DFX_ACCUM_OFS) ? {24'h0, accum_ff} :
                        (ra == `DFX_STATUS_OFS) ? status_word :
                        (ra == `DFX_MADDR_OFS) ? {20'h0, maddr_ff} :
                        (ra == `DFX_MDATA_OFS && ram_hit) ? {24'h0, ram[maddr_ff]} :
                        (ra == `DFX_IBASE_OFS) ? {20'h0, ibase_ff} : 32'h0;

  // Decrement result and its flags; borrow flags use the subtract convention
  // of the core, set when no borrow occurs
  wire [7:0] dec_val = 8'(operand_ff - 8'h01);
  dfx_flags_s dec_flags;
  assign dec_flags.borrow_out_flag = operand_ff != 8'h00;
  assign dec_flags.half_byte_borrow_flag = operand_ff[3:0] != 4'h0;
  assign dec_flags.result_null_flag = dec_val == 8'h00;
  assign dec_flags.signed_wrap_flag = operand_ff == 8'h80;
  assign dec_flags.msb_set_flag = dec_val[7];

  // Skip decision taken from the computed result
  wire res_zero = result_ff == 8'h00;
  wire take_skip = (op_ff == OP_DSZ && res_zero) || (op_ff == OP_DSNZ && !res_zero);
  wire q4_ram_wr = state_ff == ST_Q4 && instr_ff.dest && op_ff != OP_NONE;
  wire q4_acc_wr = state_ff == ST_Q4 && !instr_ff.dest && op_ff != OP_NONE;

  // Phase sequencer: decode, read, compute, write, then optional no-op cycles
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = wr_instr ? ST_Q1 : ST_IDLE;
      ST_Q1: nxt_state = (dec_op == OP_NONE) ? ST_IDLE : ST_Q2;
      ST_Q2: nxt_state = ST_Q3;
      ST_Q3: nxt_state = ST_Q4;
      ST_Q4: nxt_state = take_skip ? ST_NOP : ST_IDLE;
      ST_NOP: nxt_state = (phase_ff == `DFX_PHASES && nop_words_ff == 2'h1) ? ST_IDLE : ST_NOP;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer state, operand path and skip counters
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      eaddr_ff <= 12'h000;
      operand_ff <= 8'h00;
      result_ff <= 8'h00;
      dec_flags_q <= '0;
      phase_ff <= 2'h0;
      nop_words_ff <= 2'h0;
      cyc_ff <= 2'h0;
      ill_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      done_ff <= busy && nxt_state == ST_IDLE;
      if (state_ff == ST_Q1)
      begin
        op_ff <= dec_op;
        ill_ff <= dec_op == OP_NONE;
        eaddr_ff <= file_addr(instr_ff, ext_en_ff, bank_ff, ibase_ff);
        cyc_ff <= 2'h1;
      end
      if (state_ff == ST_Q2)
        operand_ff <= in_mem(eaddr_ff) ? ram[eaddr_ff] : 8'h00;
      // Flags computed in the process phase, held for the write phase
      if (state_ff == ST_Q3)
      begin
        result_ff <= dec_val;
        dec_flags_q <= dec_flags;
      end
      if (state_ff == ST_Q4 && take_skip)
      begin
        nop_words_ff <= next_two_word ? 2'h2 : 2'h1;
        cyc_ff <= next_two_word ? 2'h3 : 2'h2;
        phase_ff <= 2'h0;
      end
      else if (state_ff == ST_NOP)
      begin
        phase_ff <= 2'(phase_ff + 2'h1);
        if (phase_ff == `DFX_PHASES)
          nop_words_ff <= 2'(nop_words_ff - 2'h1);
      end
    end
  end

  // Software-visible registers; execution writes win since software
  // writes to these are refused while busy
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_ff <= '0;
      accum_ff <= 8'h00;
      flags_ff <= '0;
      ext_en_ff <= 1'b0;
      bank_ff <= 4'h0;
      maddr_ff <= 12'h000;
      ibase_ff <= 12'h000;
    end
    else
    begin
      if (wr_instr)
        instr_ff <= instr_new[15:0];
      if (q4_acc_wr)
        accum_ff <= result_ff;
      else if (wr_accum)
        accum_ff <= accum_new[7:0];
      if (state_ff == ST_Q4 && op_ff == OP_DEC)
        flags_ff <= dec_flags_q;
      else if (wr_status)
        flags_ff <= stat_new[4:0];
      if (wr_ctrl)
      begin
        ext_en_ff <= ctrl_new[`DFX_CTRL_EXT_BIT];
        bank_ff <= ctrl_new[`DFX_CTRL_BANK_LSB +: 4];
      end
      if (wr_maddr)
        maddr_ff <= maddr_new[11:0];
      if (wr_ibase)
        ibase_ff <= ibase_new[11:0];
    end
  end

  // Data memory: execution write-back in the last phase, or software access
  always_ff @(posedge ref_clk)
  begin
    if (q4_ram_wr && in_mem(eaddr_ff))
      ram[eaddr_ff] <= result_ff;
    else if (wr_mdata && ram_hit)
      ram[maddr_ff] <= mdata_new[7:0];
  end

  // AXI4-Lite handshakes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bresp_ff <= `DFX_RESP_OKAY;
      rdata_ff <= 32'h0;
      rresp_ff <= `DFX_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_ff)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_ff)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? `DFX_RESP_OKAY : `DFX_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mapped ? rd_word : 32'h0;
        rresp_ff <= rd_mapped ? `DFX_RESP_OKAY : `DFX_RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end
endmodule

/* File: logic/dfx_consts.svh */
// Constants for the decrement-file execution block: register offsets,
// field positions, opcodes, the access bank split and phase counts.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DFX_CONSTS_SVH
`define DFX_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define DFX_CTRL_OFS 8'h00
`define DFX_INSTR_OFS 8'h04
`define DFX_ACCUM_OFS 8'h08
`define DFX_STATUS_OFS 8'h0C
`define DFX_MADDR_OFS 8'h10
`define DFX_MDATA_OFS 8'h14
`define DFX_IBASE_OFS 8'h18

// CTRL fields
`define DFX_CTRL_EXT_BIT 0
`define DFX_CTRL_BANK_LSB 8
// STATUS fields: flags in [4:0], busy, illegal, cycles of last instruction
`define DFX_STAT_BUSY_BIT 8
`define DFX_STAT_ILL_BIT 9
`define DFX_STAT_CYC_LSB 16

// Upper six bits of each instruction word
`define DFX_OPC_DEC 6'h01
`define DFX_OPC_DSZ 6'h0B
`define DFX_OPC_DSNZ 6'h13

// Access bank split and indexed-offset limit
`define DFX_ACCESS_SPLIT 8'h60
`define DFX_INDEX_LIMIT 8'h5F
`define DFX_SFR_BANK 4'hF

// Index of the last phase in a four-phase instruction cycle
`define DFX_PHASES 2'h3

// AXI responses
`define DFX_RESP_OKAY 2'h0
`define DFX_RESP_SLVERR 2'h2

`endif

/* File: logic/dfx_pkg.sv */
// Types for the decrement-file execution block.
// Assumes dfx_consts.svh is on the include path.
package dfx_pkg;
  `include "dfx_consts.svh"

  typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_NOP} dfx_state_e;

  typedef enum logic [1:0] {OP_NONE, OP_DEC, OP_DSZ, OP_DSNZ} dfx_op_e;

  // Instruction word fields
  typedef struct packed {
    logic [5:0] opc;
    logic dest;
    logic acc;
    logic [7:0] faddr;
  } dfx_instr_s;

  // Arithmetic flags, bit 0 upward: borrow-out, half-byte, null, wrap, msb
  typedef struct packed {
    logic msb_set_flag;
    logic signed_wrap_flag;
    logic result_null_flag;
    logic half_byte_borrow_flag;
    logic borrow_out_flag;
  } dfx_flags_s;
endpackage

/* File: verif/dfx_exec_monitor.sv */
// Port checker for the decrement execution block.
// Assumes it is bound into dfx_decrement_exec with one clock.
`timescale 1ns/1ps
module dfx_exec_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_busy,
  input wire logic exec_done
);
  logic [3:0] busy_cnt_ff;
  logic [3:0] nxt_busy_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Busy length counter; a skip must add whole four-phase cycles
  assign nxt_busy_cnt = exec_busy ? busy_cnt_ff + 4'h1 : 4'h0;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_ff <= 4'h0;
    else
      busy_cnt_ff <= nxt_busy_cnt;
  end

  a_busy_length: assert property ($fell(exec_busy) |-> busy_cnt_ff inside {1, 4, 8, 12})
    else $error("busy length is not whole instruction cycles");
  a_done_after_busy: assert property ($fell(exec_busy) |-> exec_done)
    else $error("done missing after busy");
  a_done_single: assert property (exec_done |-> !exec_busy ##1 !exec_done)
    else $error("done not a single idle pulse");
  a_done_cause: assert property (exec_done |-> $past(exec_busy))
    else $error("done without execution");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ready_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule

bind dfx_decrement_exec dfx_exec_monitor u_mon (.ref_clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .exec_busy, .exec_done);

/* File: verif/dfx_decrement_exec_tb.sv */
// Self-checking bench for the decrement execution block over AXI4-Lite.
// Assumes package, header, design and checker are compiled first.
`timescale 1ns/1ps
`include "dfx_consts.svh"
module dfx_decrement_exec_tb;
  import dfx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic next_two_word = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic exec_busy, exec_done;
  int mismatches = 0;
  int total_checks = 0;

  dfx_decrement_exec dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .next_two_word, .exec_busy, .exec_done);

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // A hang counts as a mismatch and ends the run
  task automatic give_up();
    mismatches++;
    tally_and_finish();
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 40) give_up();
    end
    while (!s_axi_bvalid);
    check("write resp", {30'h0, s_axi_bresp}, {30'h0, `DFX_RESP_OKAY});
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 40) give_up();
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (!exec_done)
    begin
      @(posedge ref_clk);
      n++;
      if (n > 40) give_up();
    end
  endtask

  // Preloads one byte, runs one word, returns the destination and status
  task automatic run(input logic [15:0] w, input logic [11:0] ma, input logic [7:0] pre,
      input logic two, output logic [31:0] res, output logic [31:0] st);
    logic [1:0] r;
    wr(`DFX_MADDR_OFS, {20'h0, ma});
    wr(`DFX_MDATA_OFS, {24'h0, pre});
    next_two_word <= two;
    wr(`DFX_INSTR_OFS, {16'h0, w});
    wait_done();
    rd(w[9] ? `DFX_MDATA_OFS : `DFX_ACCUM_OFS, res, r);
    rd(`DFX_STATUS_OFS, st, r);
    st = st & 32'h0003031F;
  endtask

  task automatic t_plain();
    logic [31:0] v, st;
    wr(`DFX_CTRL_OFS, 32'h200);
    run({`DFX_OPC_DEC, 2'b11, 8'h10}, 12'h210, 8'h01, 1'b0, v, st);
    check("banked file", v, 32'h0);
    check("status", st, 32'h00010007);
    run({`DFX_OPC_DEC, 2'b00, 8'h05}, 12'h005, 8'h80, 1'b0, v, st);
    check("accumulator", v, 32'h7F);
    check("status", st, 32'h00010009);
    run({`DFX_OPC_DEC, 2'b10, 8'hA0}, 12'hFA0, 8'h00, 1'b0, v, st);
    check("upper access", v, 32'hFF);
    check("status", st, 32'h00010010);
  endtask

  // Boundary address of the indexed offset window
  task automatic t_indexed();
    logic [31:0] v, st;
    wr(`DFX_CTRL_OFS, 32'h1);
    wr(`DFX_IBASE_OFS, 32'h300);
    run({`DFX_OPC_DEC, 2'b10, 8'h5F}, 12'h35F, 8'h05, 1'b0, v, st);
    check("indexed file", v, 32'h04);
    check("status", st, 32'h00010003);
    wr(`DFX_CTRL_OFS, 32'h200);
  endtask

  task automatic t_skip_zero();
    logic [31:0] v, st;
    wr(`DFX_STATUS_OFS, 32'h15);
    run({`DFX_OPC_DSZ, 2'b11, 8'h33}, 12'h233, 8'h01, 1'b0, v, st);
    check("file", v, 32'h0);
    check("status", st, 32'h00020015);
    run({`DFX_OPC_DSZ, 2'b11, 8'h33}, 12'h233, 8'h01, 1'b1, v, st);
    check("status", st, 32'h00030015);
    run({`DFX_OPC_DSZ, 2'b11, 8'h33}, 12'h233, 8'h03, 1'b1, v, st);
    check("file", v, 32'h02);
    check("status", st, 32'h00010015);
  endtask

  task automatic t_skip_nonzero();
    logic [31:0] v, st;
    wr(`DFX_STATUS_OFS, 32'h0A);
    run({`DFX_OPC_DSNZ, 2'b01, 8'h44}, 12'h244, 8'h05, 1'b0, v, st);
    check("accumulator", v, 32'h04);
    check("status", st, 32'h0002000A);
    run({`DFX_OPC_DSNZ, 2'b01, 8'h44}, 12'h244, 8'h05, 1'b1, v, st);
    check("status", st, 32'h0003000A);
    run({`DFX_OPC_DSNZ, 2'b01, 8'h44}, 12'h244, 8'h01, 1'b1, v, st);
    check("accumulator", v, 32'h0);
    check("status", st, 32'h0001000A);
  endtask

  // Accumulator write during the write phase of a long-skipping instruction is dropped; the instruction writes
  // the file so only a wrongly taken write could change the accumulator;
  // unmapped read errs; an unknown opcode raises the illegal bit and sets a cycle count of one, leaving file and flags
  task automatic t_refused();
    logic [31:0] v, st;
    logic [1:0] r;
    wr(`DFX_MADDR_OFS, 32'h050);
    wr(`DFX_MDATA_OFS, 32'h01);
    next_two_word <= 1'b1;
    wr(`DFX_INSTR_OFS, {16'h0, `DFX_OPC_DSZ, 2'b10, 8'h50});
    wr(`DFX_ACCUM_OFS, 32'h55);
    wait_done();
    rd(`DFX_ACCUM_OFS, v, r);
    check("accumulator", v, 32'h0);
    rd(8'h1C, v, r);
    check("unmapped resp", {30'h0, r}, {30'h0, `DFX_RESP_SLVERR});
    check("unmapped data", v, 32'h0);
    run({6'h00, 2'b11, 8'h33}, 12'h233, 8'h07, 1'b0, v, st);
    check("illegal file", v, 32'h07);
    check("illegal status", st, 32'h0001020A);
  endtask

  // Reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_plain();
    t_indexed();
    t_skip_zero();
    t_skip_nonzero();
    t_refused();
    tally_and_finish();
  end
endmodule
